// *** pucr_regs.svh ***
// Register offsets, field positions, reset values and codes for the strap block
`ifndef PUCR_REGS_SVH
`define PUCR_REGS_SVH

`define PUCR_CTRL_OFS      12'h000
`define PUCR_STRAP_OFS     12'h004
`define PUCR_RATIO_OFS     12'h008
`define PUCR_STAT_OFS      12'h00C
`define PUCR_LCFG_OFS      12'h010
`define PUCR_DIS_OFS       12'h014

`define PUCR_LDIV_RESET    4'h2
`define PUCR_LDIV_MIN      4'h2
`define PUCR_PLAT_RESV     16'hC882
`define PUCR_CORE_RESV     8'h04
`define PUCR_ENG_RESV      5'h01
`define PUCR_PCI_DIS_BIT   0
`define PUCR_STAT_ERR_BIT  0
`define PUCR_STAT_LAT_BIT  1

`endif

// *** pucr_pkg.sv ***
// Types shared by the strap block
package pucr_pkg;
  typedef enum logic [1:0]
  {
    PUCR_WAIT   = 2'b00,
    PUCR_SAMPLE = 2'b01,
    PUCR_HELD   = 2'b10
  } pucr_state_t;
endpackage

// *** pucr_clk_div.sv ***
// Divides an enable pulse train into a clock output, high for divide/2 ticks (rounded down) of each period
`timescale 1ns/1ns
module pucr_clk_div
  import pucr_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] divide,
  output logic                  clk_out
);
  initial
  begin
    if (WIDTH < 2)
      $error("pucr_clk_div: WIDTH too small");
  end

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             out_q;
  logic             out_d;
  logic [WIDTH-1:0] half;

  assign half = divide >> 1;

  always_comb
  begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (tick)
    begin
      if (cnt_q == '0)
      begin
        out_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
      end
      else if (cnt_q == half)
      begin
        out_d = 1'b0;
        cnt_d = (cnt_q + 1'b1 >= divide) ? '0 : cnt_q + 1'b1;
      end
      else
      begin
        cnt_d = (cnt_q + 1'b1 >= divide) ? '0 : cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
endmodule

// *** pucr_straps.sv ***
// Power-up strap capture, ratio decode and local clock divider control
`timescale 1ns/1ns
`include "pucr_regs.svh"
module pucr_straps
  import pucr_pkg::*;
#(
  parameter int DIV_W = 4
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        hard_reset_n,
  input  wire logic [3:0]  platform_ratio_strap,
  input  wire logic        core_ratio_strap_bit0,
  input  wire logic        core_ratio_strap_bit1,
  input  wire logic        core_ratio_strap_bit2,
  input  wire logic [4:0]  engine_mult_strap,
  input  wire logic [1:0]  dram_type_strap_pins,
  input  wire logic        arb_internal_strap,
  input  wire logic        pci_async_strap,
  input  wire logic        platform_tick,
  input  wire logic        pci_ad_drive_req,
  output logic             local_bus_clock_out,
  output logic             mem_clock_out,
  output logic             pci_ad_oe,
  output logic [4:0]       plat_mult,
  output logic [3:0]       core_ratio_x2,
  output logic [4:0]       engine_mult,
  output logic             cfg_error,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  initial
  begin
    if (DIV_W < 4 || DIV_W > 8)
      $error("pucr_straps: DIV_W out of range");
  end

  // --------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------
  pucr_state_t st_q;
  pucr_state_t st_d;
  logic [15:0] straps_q;
  logic [15:0] straps_d;
  logic [15:0] strap_pins;

  assign strap_pins = {arb_internal_strap, pci_async_strap,
                       dram_type_strap_pins, engine_mult_strap,
                       core_ratio_strap_bit0, core_ratio_strap_bit1,
                       core_ratio_strap_bit2, platform_ratio_strap};

  // Sample on the hard reset release; do not resample until aresetn returns the capture to PUCR_WAIT
  always_comb
  begin
    st_d     = st_q;
    straps_d = straps_q;
    unique case (st_q)
      PUCR_WAIT:
        if (!hard_reset_n)
          st_d = PUCR_SAMPLE;
      PUCR_SAMPLE:
        if (hard_reset_n)
        begin
          straps_d = strap_pins;
          st_d     = PUCR_HELD;
        end
      PUCR_HELD:
        st_d = PUCR_HELD;
      default:
        st_d = PUCR_WAIT;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q     <= PUCR_WAIT;
      straps_q <= 16'h0000;
    end
    else if (ce)
    begin
      st_q     <= st_d;
      straps_q <= straps_d;
    end
  end

  logic       latched;
  logic [3:0] plat_code;
  logic [2:0] core_code;
  logic [4:0] eng_code;

  assign latched   = (st_q == PUCR_HELD);
  assign plat_code = straps_q[3:0];
  assign core_code = straps_q[6:4];
  assign eng_code  = straps_q[11:7];

  // --------------------------------------------------------------
  // Ratio decode
  // --------------------------------------------------------------
  logic plat_resv;
  logic core_resv;
  logic eng_resv;

  always_comb
  begin
    plat_resv = 1'(`PUCR_PLAT_RESV >> plat_code);
    unique case (plat_code)
      4'h0:    plat_mult = 5'h10;
      4'hD:    plat_mult = 5'h14;
      default: plat_mult = plat_resv ? 5'h00 : {1'b0, plat_code};
    endcase
    core_resv = 1'(`PUCR_CORE_RESV >> core_code);
    unique case (core_code)
      3'h0:    core_ratio_x2 = 4'h8;
      3'h1:    core_ratio_x2 = 4'h9;
      3'h3:    core_ratio_x2 = 4'h3;
      3'h4:    core_ratio_x2 = 4'h4;
      3'h5:    core_ratio_x2 = 4'h5;
      3'h6:    core_ratio_x2 = 4'h6;
      3'h7:    core_ratio_x2 = 4'h7;
      default: core_ratio_x2 = 4'h0;
    endcase
    eng_resv = (eng_code == `PUCR_ENG_RESV);
    if (eng_code == 5'h00)
      engine_mult = 5'h10;
    else if (eng_resv)
      engine_mult = 5'h00;
    else
      engine_mult = eng_code;
  end

  assign cfg_error = latched & (plat_resv | core_resv | eng_resv);

  // --------------------------------------------------------------
  // Registers and clocks
  // --------------------------------------------------------------
  logic [DIV_W-1:0] ldiv_q;
  logic [DIV_W-1:0] ldiv_d;
  logic             pdis_q;
  logic             pdis_d;
  logic             mem_q;

  // Memory clock toggles every platform tick: half rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mem_q <= 1'b0;
    else if (ce && platform_tick)
      mem_q <= ~mem_q;
  end
  assign mem_clock_out = mem_q;

  pucr_clk_div #(.WIDTH(DIV_W)) u_ldiv
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick    (platform_tick),
    .divide  (ldiv_q),
    .clk_out (local_bus_clock_out)
  );

  // Disabled block still drives when strapped as arbiter
  assign pci_ad_oe = (latched & straps_q[15]) |
                     (pci_ad_drive_req & ~pdis_q);

  // --------------------------------------------------------------
  // AXI4-Lite slave: one write, one read at a time
  // --------------------------------------------------------------
  logic        aw_q, w_q, bv_q, rv_q;
  logic        aw_d, w_d, bv_d, rv_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  assign s_axi_awready = ~aw_q & ~bv_q;
  assign s_axi_wready  = ~w_q & ~bv_q;
  assign s_axi_arready = ~rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  always_comb
  begin
    aw_d = aw_q;  w_d = w_q;  bv_d = bv_q;  rv_d = rv_q;
    awa_d = awa_q;  wd_d = wd_q;  br_d = br_q;
    rd_d = rd_q;  rr_d = rr_q;
    ldiv_d = ldiv_q;  pdis_d = pdis_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (aw_q && w_q)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = 2'b00;
      if (awa_q == `PUCR_LCFG_OFS)
      begin
        if (wd_q[DIV_W-1:0] >= DIV_W'(`PUCR_LDIV_MIN))
          ldiv_d = wd_q[DIV_W-1:0];
      end
      else if (awa_q == `PUCR_DIS_OFS)
        pdis_d = wd_q[`PUCR_PCI_DIS_BIT];
      else
        br_d = 2'b10;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_d = 1'b1;
      rr_d = 2'b00;
      unique case (s_axi_araddr)
        `PUCR_CTRL_OFS:  rd_d = {30'h0, latched, cfg_error};
        `PUCR_STRAP_OFS: rd_d = {16'h0, straps_q};
        `PUCR_RATIO_OFS: rd_d = {15'h0, engine_mult, core_ratio_x2,
                                 3'h0, plat_mult};
        `PUCR_STAT_OFS:  rd_d = {30'h0, latched, cfg_error};
        `PUCR_LCFG_OFS:  rd_d = 32'(ldiv_q);
        `PUCR_DIS_OFS:   rd_d = {31'h0, pdis_q};
        default:
        begin
          rd_d = 32'h0000_0000;
          rr_d = 2'b10;
        end
      endcase
    end
    else if (rv_q && s_axi_rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
      awa_q <= 12'h000;  wd_q <= 32'h0;  br_q <= 2'b00;
      rd_q <= 32'h0;  rr_q <= 2'b00;
      ldiv_q <= DIV_W'(`PUCR_LDIV_RESET);
      pdis_q <= 1'b0;
    end
    else if (ce)
    begin
      aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
      awa_q <= awa_d;  wd_q <= wd_d;  br_q <= br_d;
      rd_q <= rd_d;  rr_q <= rr_d;
      ldiv_q <= ldiv_d;
      pdis_q <= pdis_d;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_hold_straps;
    @(posedge aclk) disable iff (!aresetn)
    (latched && ce) |=> (latched && $stable(straps_q));
  endproperty
  a_hold_straps: assert property (p_hold_straps)
    else $error("straps changed after latch");

  property p_plat_zero;
    @(posedge aclk) disable iff (!aresetn)
    (plat_code == 4'h0) |-> (plat_mult == 5'h10);
  endproperty
  a_plat_zero: assert property (p_plat_zero)
    else $error("platform code zero not sixteen");

  property p_plat_resv;
    @(posedge aclk) disable iff (!aresetn)
    (latched && plat_code == 4'hB) |-> cfg_error;
  endproperty
  a_plat_resv: assert property (p_plat_resv)
    else $error("reserved platform code not flagged");

  property p_core_resv;
    @(posedge aclk) disable iff (!aresetn)
    (latched && core_code == 3'h2) |-> cfg_error;
  endproperty
  a_core_resv: assert property (p_core_resv)
    else $error("reserved core code not flagged");

  property p_core_four;
    @(posedge aclk) disable iff (!aresetn)
    (core_code == 3'h0) |-> (core_ratio_x2 == 4'h8);
  endproperty
  a_core_four: assert property (p_core_four)
    else $error("core code zero wrong");

  property p_eng;
    @(posedge aclk) disable iff (!aresetn)
    (eng_code > 5'h01) |-> (engine_mult == eng_code);
  endproperty
  a_eng: assert property (p_eng)
    else $error("engine multiplier wrong");

  property p_mem_half;
    @(posedge aclk) disable iff (!aresetn)
    // A tick on the last reset edge must not count: reset wins there
    (aresetn && ce && platform_tick) |=> (mem_q != $past(mem_q));
  endproperty
  a_mem_half: assert property (p_mem_half)
    else $error("memory clock did not toggle");

  property p_arb_drive;
    @(posedge aclk) disable iff (!aresetn)
    (latched && straps_q[15]) |-> pci_ad_oe;
  endproperty
  a_arb_drive: assert property (p_arb_drive)
    else $error("arbiter stopped driving");

  property p_ldiv_min;
    @(posedge aclk) disable iff (!aresetn)
    ldiv_q >= DIV_W'(`PUCR_LDIV_MIN);
  endproperty
  a_ldiv_min: assert property (p_ldiv_min)
    else $error("divider below minimum");
endmodule

// *** pucr_board.sv ***
// Board model: strap resistors, hard reset pulse and platform tick
`timescale 1ns/1ns
module pucr_board
#(
  parameter int TICK_DIV = 3,
  parameter int HR_LEN   = 4
)
(
  input  wire logic        aclk,
  input  wire logic        hr_go,
  input  wire logic [15:0] strap_set,
  output logic             hard_reset_n,
  output logic             platform_tick,
  output logic [15:0]      straps
);
  logic [3:0] hr_q = 4'h0;
  logic [3:0] tk_q = 4'h0;
  // Resistors hold every strap firm from time zero, reset or not
  assign straps = strap_set;
  always_ff @(posedge aclk)
  begin
    hr_q <= hr_go ? 4'(HR_LEN) : ((hr_q != 4'h0) ? hr_q - 4'h1 : hr_q);
    tk_q <= (tk_q == 4'(TICK_DIV - 1)) ? 4'h0 : tk_q + 4'h1;
  end
  // Boot hold line is left open: its pull-up keeps it high in reset
  assign hard_reset_n  = (hr_q == 4'h0);
  // Free running from time zero, at the memory data rate
  assign platform_tick = (tk_q == 4'h0);
endmodule

// *** pucr_straps_bench.sv ***
// Self-checking bench for the strap capture block
`timescale 1ns/1ns
module pucr_straps_bench;
  logic aclk = 1'h0, aresetn = 1'h0, hr_go = 1'h0, req = 1'h0;
  logic [15:0] sset = 16'h0000, st;
  logic hrn, tick, lbc, memc, oe, err, awr, wr, bv, arr, rv, e_err;
  logic [4:0] pm, em;
  logic [3:0] cx;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd, r;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [1:0] bresp, rresp;
  logic [33:0] expq[$];
  int errors = 0, n_compared = 0, lb_n = 0, lb_per = 0, mc_n = 0, mc_per = 0;
  logic lbp = 1'h0, mcp = 1'h0;

  initial forever #20 aclk = ~aclk;

  pucr_board board (.aclk(aclk), .hr_go(hr_go), .strap_set(sset),
    .hard_reset_n(hrn), .platform_tick(tick), .straps(st));

  pucr_straps #(.DIV_W(4)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .hard_reset_n(hrn), .platform_ratio_strap(st[3:0]),
    .core_ratio_strap_bit0(st[6]), .core_ratio_strap_bit1(st[5]),
    .core_ratio_strap_bit2(st[4]), .engine_mult_strap(st[11:7]),
    .dram_type_strap_pins(st[13:12]), .arb_internal_strap(st[15]),
    .pci_async_strap(st[14]), .platform_tick(tick), .pci_ad_drive_req(req),
    .local_bus_clock_out(lbc), .mem_clock_out(memc), .pci_ad_oe(oe),
    .plat_mult(pm), .core_ratio_x2(cx), .engine_mult(em), .cfg_error(err),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));

  task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Ready is read mid-cycle, so it is the level the next edge samples
  task automatic await(ref logic s);
    logic ok;
    ok = 1'h0;
    while (!ok)
    begin
      @(negedge aclk);
      ok = s;
      @(posedge aclk);
    end
  endtask

  task automatic wr_reg(logic [11:0] a, logic [31:0] d, logic [1:0] eb);
    logic da, dw, oa, ow;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      oa = awr && awv;
      ow = wr && wv;
      @(posedge aclk);
      awv <= awv && !oa;
      wv <= wv && !ow;
      da |= oa;
      dw |= ow;
    end
    await(bv);
    check("bresp", 34'(bresp), 34'(eb));
    br <= 1'h0;
  endtask

  task automatic rd_reg(logic [11:0] a, logic [33:0] e);
    expq.push_back(e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    await(arr);
    arv <= 1'h0;
    await(rv);
    rr <= 1'h0;
  endtask

  task automatic pulse_hr();
    hr_go <= 1'h1;
    @(posedge aclk);
    hr_go <= 1'h0;
    repeat (8) @(posedge aclk);
  endtask

  function automatic logic [31:0] ratio(logic [15:0] s);
    logic [4:0] p;
    logic [3:0] c;
    logic [4:0] e;
    case (s[3:0])
      4'h0: p = 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC: p = 5'(s[3:0]);
      4'hD: p = 5'h14;
      default: p = 5'h00;
    endcase
    case (s[6:4])
      3'h0: c = 4'h8;
      3'h1: c = 4'h9;
      3'h2: c = 4'h0;
      default: c = 4'(s[6:4]);
    endcase
    e = (s[11:7] == 5'h00) ? 5'h10 : ((s[11:7] == 5'h01) ? 5'h00 : s[11:7]);
    return {15'h0, e, c, 3'h0, p};
  endfunction

  // ------------------------------------------------------------
  // Watchers: read data queue and divided clock periods in ticks
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (rv && rr)
      check("read", {rresp, rd}, expq.pop_front());
    lbp <= lbc;
    mcp <= memc;
    lb_n <= (lbc && !lbp) ? int'(tick) : lb_n + int'(tick);
    mc_n <= (memc && !mcp) ? int'(tick) : mc_n + int'(tick);
    if (lbc && !lbp)
      lb_per <= lb_n;
    if (memc && !mcp)
      mc_per <= mc_n;
  end

  initial
  begin
    #2000000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h49a984b0));
    for (int i = 0; i < 32; i++)
    begin
      aresetn <= 1'h0;
      sset <= {4'($urandom()), 5'(i), 3'(i / 4), 4'(i)};
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      rd_reg(12'h00C, 34'h0);
      pulse_hr();
      r = ratio(sset);
      e_err = (r[4:0] == 5'h0) || (r[11:8] == 4'h0) || (r[16:12] == 5'h0);
      rd_reg(12'h004, {18'h0, sset});
      rd_reg(12'h008, {2'h0, r});
      rd_reg(12'h00C, {2'h0, 30'h0, 1'h1, e_err});
      check("decode", {em, cx, 3'h0, pm}, r[16:0]);
      check("cfg_error", err, e_err);
      req <= 1'h1;
      wr_reg(12'h014, 32'h1, 2'h0);
      @(negedge aclk);
      check("pci_oe", oe, sset[15]);
      wr_reg(12'h014, 32'h0, 2'h0);
      @(negedge aclk);
      check("pci_oe", oe, 1'h1);
      sset <= sset ^ 16'h0FFF;
      pulse_hr();
      rd_reg(12'h008, {2'h0, r});
    end
    rd_reg(12'h010, 34'h2);
    for (int d = 2; d < 6; d++)
    begin
      wr_reg(12'h010, 32'(d), 2'h0);
      repeat (80) @(posedge aclk);
      check("local_div", lb_per, d);
    end
    wr_reg(12'h010, 32'h1, 2'h0);
    rd_reg(12'h010, 34'h5);
    check("mem_div", mc_per, 2);
    wr_reg(12'h020, 32'h0, 2'h2);
    rd_reg(12'h020, {2'h2, 32'h0});
    report_and_stop();
  end
endmodule
